//--- logic/pcg_consts.vh
// Constants for the pixel clock generator configuration block
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// Register offsets on the serial control port
`define PCG_OFS_VERSION     8'h00
`define PCG_OFS_DIV_HIGH    8'h01
`define PCG_OFS_DIV_LOW     8'h02
`define PCG_OFS_CLK_CFG     8'h03
`define PCG_OFS_PHASE       8'h04

// Power-up register contents
`define PCG_RST_DIV_HIGH    8'h69
`define PCG_RST_DIV_LOW_NIB 4'hD
`define PCG_RST_RATIO       12'h69D
`define PCG_RST_BAND        2'h1
`define PCG_RST_PUMP        3'h1
`define PCG_RST_EXT_SEL     1'h0
`define PCG_RST_PHASE       5'h10

// Field positions
`define PCG_DIV_LOW_MSB     7
`define PCG_DIV_LOW_LSB     4
`define PCG_BAND_MSB        7
`define PCG_BAND_LSB        6
`define PCG_PUMP_MSB        5
`define PCG_PUMP_LSB        3
`define PCG_EXT_SEL_BIT     2
`define PCG_PHASE_MSB       7
`define PCG_PHASE_LSB       3

// Supported divide ratio span
`define PCG_RATIO_MIN       12'h0DD
`define PCG_RATIO_MAX       12'hFFF

// Phase steps per pixel period
`define PCG_PHASE_STEPS     6'h20

// Serial port: slave address, arbitrary value
`define PCG_DEV_ADDR        7'h4C
// Bits per serial byte
`define PCG_BYTE_BITS       4'h8

`endif

//--- logic/pcg_pin_sync.v
// Two-stage synchroniser for the serial control pins
`timescale 1ns/1ps
`default_nettype none

module pcg_pin_sync #(
    parameter WIDTH = 2
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync
);

    genvar i;

    // One pair of flops per pin; idle level of the bus is high
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_ff;
            reg sync_ff;
            always @(posedge ref_clk) begin
                if (rst) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                end else begin
                    meta_ff <= pin_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign pin_sync[i] = sync_ff;
        end
    endgenerate

endmodule

`default_nettype wire

//--- logic/pcg_clock_config.v
// Pixel clock generator configuration registers behind a 2-wire port
//
// Function
// R1 - Divide ratio is 12 bits: high register, then low register bits [7:4].
// R2 - New ratio takes effect only on a low register write.
// R3 - Host keeps the divide ratio between 221 and 4095.
// R4 - PLL locks pixel clock divided by ratio to horizontal sync.
// R5 - Ratio resets to 1693, high register to 0x69.
// R6 - Band field [7:6] picks pixel rate range 12-30 up to 120-150.
// R7 - PLL post-divisor follows the band field automatically.
// R8 - Band field resets to 01.
// R9 - Pump field [5:3] selects loop filter current 50 to 1500 uA.
// R10 - Pump field resets to 001, 100 uA.
// R11 - Bit 2 picks clock source: 0 internal PLL, 1 external pin.
// R12 - External source ignores divide ratio but keeps phase adjustment.
// R13 - External select resets to 0.
// R14 - Phase field [7:3] steps sampling edge in 32 steps of 11.25 deg.
// R15 - Phase field resets to 16.
// R16 - Address zero reads silicon revision; writes do nothing.
// R17 - All fields take defaults on reset before any host write.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"

module pcg_clock_config #(
    parameter [7:0] SILICON_VERSION = 8'h01  // Arbitrary value
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_ff,
    output reg         sda_oe_ff,
    output reg  [11:0] line_divide_ratio_ff,
    output reg         pll_feedback_enable_ff,
    output reg         external_pixel_clock_select_ff,
    output reg  [1:0]  oscillator_band_select_ff,
    output reg  [1:0]  post_divide_log2_ff,
    output reg         pump_current_bit2_ff,
    output reg         pump_current_bit1_ff,
    output reg         pump_current_bit0_ff,
    output reg  [10:0] pump_current_ua_ff,
    output reg  [4:0]  sampling_phase_ff,
    output reg         ratio_in_span_ff
);

    // Serial port states
    // Bits are taken on the SCL rise and answers change on the SCL fall,
    // so the line never changes while the host may be sampling it
    localparam [3:0] ST_IDLE      = 4'h0;
    localparam [3:0] ST_ADDR      = 4'h1;
    localparam [3:0] ST_ADDR_ACK  = 4'h2;
    localparam [3:0] ST_SUB       = 4'h3;
    localparam [3:0] ST_SUB_ACK   = 4'h4;
    localparam [3:0] ST_WDATA     = 4'h5;
    localparam [3:0] ST_WDATA_ACK = 4'h6;
    localparam [3:0] ST_RDATA     = 4'h7;
    localparam [3:0] ST_RDATA_ACK = 4'h8;

    wire       scl_s;
    wire       sda_s;
    reg        scl_d_ff;
    reg        sda_d_ff;
    reg [3:0]  state_ff;
    reg [3:0]  bit_cnt_ff;
    reg [7:0]  shift_ff;
    reg [7:0]  tx_ff;
    reg [7:0]  ptr_ff;
    reg        rw_ff;
    reg        nack_ff;
    reg        wr_stb_ff;
    reg [7:0]  wr_addr_ff;
    reg [7:0]  wr_data_ff;

    // Register file
    // Low nibble kept only for readback; the live ratio has its own copy
    reg [7:0]  div_high_ff;
    reg [3:0]  div_low_ff;
    reg [1:0]  band_ff;
    reg [2:0]  pump_ff;
    reg        ext_sel_ff;
    reg [4:0]  phase_ff;

    reg [7:0]  rd_data;
    reg [1:0]  nxt_post_div;
    reg [10:0] nxt_pump_ua;
    wire [11:0] nxt_ratio;

    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;

    // Pins come from another domain, so resynchronise first
    pcg_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   ({scl_in, sda_in}),
        .pin_sync ({scl_s, sda_s})
    );

    // Bus events from synchronised levels only
    // Both SCL samples high, so SDA moves while SCL is low never frame
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Read mux; reserved bits and unmapped offsets read zero
    always @* begin
        case (ptr_ff)
            `PCG_OFS_VERSION:  rd_data = SILICON_VERSION;  // R16
            `PCG_OFS_DIV_HIGH: rd_data = div_high_ff;
            `PCG_OFS_DIV_LOW:  rd_data = {div_low_ff, 4'h0};
            `PCG_OFS_CLK_CFG:  rd_data = {band_ff, pump_ff, ext_sel_ff, 2'h0};
            `PCG_OFS_PHASE:    rd_data = {phase_ff, 3'h0};
            default:           rd_data = 8'h00;
        endcase
    end

    // Serial port state machine; a start always wins over other events
    always @(posedge ref_clk) begin
        if (rst) begin
            scl_d_ff   <= 1'b1;
            sda_d_ff   <= 1'b1;
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            tx_ff      <= 8'h00;
            ptr_ff     <= 8'h00;
            rw_ff      <= 1'b0;
            nack_ff    <= 1'b0;
            sda_oe_ff  <= 1'b0;
            sda_out_ff <= 1'b0;
            wr_stb_ff  <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            scl_d_ff   <= scl_s;
            sda_d_ff   <= sda_s;
            sda_out_ff <= 1'b0;  // Open drain: only ever pulls low
            wr_stb_ff  <= 1'b0;
            // A repeated start restarts the byte count in mid-frame
            if (bus_start) begin
                state_ff   <= ST_ADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe_ff  <= 1'b0;
            end else if (bus_stop) begin
                state_ff  <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end else if (scl_rise) begin
                case (state_ff)
                    ST_ADDR, ST_SUB, ST_WDATA: begin
                        shift_ff   <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    ST_RDATA_ACK: begin
                        nack_ff <= sda_s;
                    end
                    default: begin
                        nack_ff <= nack_ff;
                    end
                endcase
            end else if (scl_fall) begin
                case (state_ff)
                    ST_ADDR: begin
                        if (bit_cnt_ff == `PCG_BYTE_BITS) begin
                            // Other addresses: drop off the bus until next start
                            if (shift_ff[7:1] == `PCG_DEV_ADDR) begin
                                rw_ff     <= shift_ff[0];
                                sda_oe_ff <= 1'b1;
                                state_ff  <= ST_ADDR_ACK;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (rw_ff) begin
                            tx_ff      <= rd_data;
                            sda_oe_ff  <= ~rd_data[7];
                            bit_cnt_ff <= 4'h1;
                            state_ff   <= ST_RDATA;
                        end else begin
                            sda_oe_ff  <= 1'b0;
                            bit_cnt_ff <= 4'h0;
                            state_ff   <= ST_SUB;
                        end
                    end
                    ST_SUB: begin
                        if (bit_cnt_ff == `PCG_BYTE_BITS) begin
                            ptr_ff    <= shift_ff;
                            sda_oe_ff <= 1'b1;
                            state_ff  <= ST_SUB_ACK;
                        end
                    end
                    ST_SUB_ACK, ST_WDATA_ACK: begin
                        sda_oe_ff  <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (bit_cnt_ff == `PCG_BYTE_BITS) begin
                            // Write lands one cycle later; pointer auto-increments
                            wr_stb_ff  <= 1'b1;
                            wr_addr_ff <= ptr_ff;
                            wr_data_ff <= shift_ff;
                            ptr_ff     <= ptr_ff + 8'h01;
                            sda_oe_ff  <= 1'b1;
                            state_ff   <= ST_WDATA_ACK;
                        end
                    end
                    ST_RDATA: begin
                        if (bit_cnt_ff == `PCG_BYTE_BITS) begin
                            sda_oe_ff <= 1'b0;  // Host drives acknowledge
                            ptr_ff    <= ptr_ff + 8'h01;
                            state_ff  <= ST_RDATA_ACK;
                        end else begin
                            tx_ff      <= {tx_ff[6:0], 1'b0};
                            sda_oe_ff  <= ~tx_ff[6];
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (nack_ff) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            tx_ff      <= rd_data;
                            sda_oe_ff  <= ~rd_data[7];
                            bit_cnt_ff <= 4'h1;
                            state_ff   <= ST_RDATA;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Ratio staged from held high byte and freshly written low nibble
    // A high byte alone never reaches the PLL, so no half-written ratio goes live
    assign nxt_ratio = {div_high_ff, wr_data_ff[`PCG_DIV_LOW_MSB:`PCG_DIV_LOW_LSB]};  // R1

    // Register writes; revision and unmapped offsets ignore writes
    // One strobe per data byte; the pointer has already moved on
    always @(posedge ref_clk) begin
        if (rst) begin
            div_high_ff          <= `PCG_RST_DIV_HIGH;  // R5 R17
            div_low_ff           <= `PCG_RST_DIV_LOW_NIB;  // R5
            band_ff              <= `PCG_RST_BAND;  // R8
            pump_ff              <= `PCG_RST_PUMP;  // R10
            ext_sel_ff           <= `PCG_RST_EXT_SEL;  // R13
            phase_ff             <= `PCG_RST_PHASE;  // R15
            line_divide_ratio_ff <= `PCG_RST_RATIO;  // R5
        end else if (wr_stb_ff) begin
            case (wr_addr_ff)
                `PCG_OFS_DIV_HIGH: begin
                    // Held only; active ratio untouched
                    div_high_ff <= wr_data_ff;  // R2
                end
                `PCG_OFS_DIV_LOW: begin
                    div_low_ff           <= wr_data_ff[`PCG_DIV_LOW_MSB:`PCG_DIV_LOW_LSB];
                    line_divide_ratio_ff <= nxt_ratio;  // R2
                end
                `PCG_OFS_CLK_CFG: begin
                    band_ff    <= wr_data_ff[`PCG_BAND_MSB:`PCG_BAND_LSB];  // R6
                    pump_ff    <= wr_data_ff[`PCG_PUMP_MSB:`PCG_PUMP_LSB];  // R9
                    ext_sel_ff <= wr_data_ff[`PCG_EXT_SEL_BIT];  // R11
                end
                `PCG_OFS_PHASE: begin
                    phase_ff <= wr_data_ff[`PCG_PHASE_MSB:`PCG_PHASE_LSB];  // R14
                end
                default: begin
                    phase_ff <= phase_ff;  // R16
                end
            endcase
        end
    end

    // Post-divisor: slow bands run the oscillator fast and divide down
    // Log2 encoding keeps the divisor field two bits wide
    always @* begin
        case (band_ff)
            2'h0:    nxt_post_div = 2'h3;  // R7
            2'h1:    nxt_post_div = 2'h2;
            2'h2:    nxt_post_div = 2'h1;
            default: nxt_post_div = 2'h0;
        endcase
    end

    // Loop filter drive current in microamps per pump code
    // Plain table in code order; the steps are not evenly spaced
    always @* begin
        case (pump_ff)
            3'h0:    nxt_pump_ua = 11'h032;  // R9
            3'h1:    nxt_pump_ua = 11'h064;
            3'h2:    nxt_pump_ua = 11'h096;
            3'h3:    nxt_pump_ua = 11'h0FA;
            3'h4:    nxt_pump_ua = 11'h15E;
            3'h5:    nxt_pump_ua = 11'h1F4;
            3'h6:    nxt_pump_ua = 11'h2EE;
            default: nxt_pump_ua = 11'h5DC;
        endcase
    end

    // Analog controls; registered so outputs never glitch
    // Costs one cycle of latency behind the register file
    always @(posedge ref_clk) begin
        if (rst) begin
            pll_feedback_enable_ff         <= 1'b1;
            external_pixel_clock_select_ff <= `PCG_RST_EXT_SEL;
            oscillator_band_select_ff      <= `PCG_RST_BAND;
            post_divide_log2_ff            <= 2'h2;
            pump_current_bit2_ff           <= 1'b0;
            pump_current_bit1_ff           <= 1'b0;
            pump_current_bit0_ff           <= 1'b1;
            pump_current_ua_ff             <= 11'h064;
            sampling_phase_ff              <= `PCG_RST_PHASE;
            ratio_in_span_ff               <= 1'b1;
        end else begin
            // Feedback divider drives the PLL lock to horizontal sync
            pll_feedback_enable_ff         <= ~ext_sel_ff;  // R4 R11 R12
            external_pixel_clock_select_ff <= ext_sel_ff;  // R11
            oscillator_band_select_ff      <= band_ff;  // R6
            post_divide_log2_ff            <= nxt_post_div;  // R7
            pump_current_bit2_ff           <= pump_ff[2];  // R9
            pump_current_bit1_ff           <= pump_ff[1];
            pump_current_bit0_ff           <= pump_ff[0];
            pump_current_ua_ff             <= nxt_pump_ua;
            // Phase applies in either clock source mode
            sampling_phase_ff              <= phase_ff;  // R12 R14
            // Status only; a ratio out of span is still applied
            ratio_in_span_ff <= (line_divide_ratio_ff >= `PCG_RATIO_MIN);  // R3
        end
    end

endmodule

`default_nettype wire

//--- tb/pcg_monitor.sv
// Port checker for the pixel clock configuration block
`timescale 1ns/1ps
`default_nettype none
module pcg_monitor (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        sda_oe_ff,
    input wire logic [11:0] line_divide_ratio_ff,
    input wire logic        pll_feedback_enable_ff,
    input wire logic        external_pixel_clock_select_ff,
    input wire logic [1:0]  oscillator_band_select_ff,
    input wire logic [1:0]  post_divide_log2_ff,
    input wire logic        pump_current_bit2_ff,
    input wire logic        pump_current_bit1_ff,
    input wire logic        pump_current_bit0_ff,
    input wire logic [10:0] pump_current_ua_ff,
    input wire logic [4:0]  sampling_phase_ff,
    input wire logic        ratio_in_span_ff
);
    localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                       11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
    wire [2:0]  pump;
    wire [10:0] cfg;
    // Grouped views; cfg bundles the band, pump, source select and phase outputs
    assign pump = {pump_current_bit2_ff, pump_current_bit1_ff, pump_current_bit0_ff};
    assign cfg = {oscillator_band_select_ff, pump, external_pixel_clock_select_ff,
                  sampling_phase_ff};
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_reset_ratio: assert property (
        $past(rst) |-> line_divide_ratio_ff == 12'h69D && ratio_in_span_ff)
        else $error("ratio not at default after reset");
    a_reset_fields: assert property (
        $past(rst) |-> oscillator_band_select_ff == 2'h1 && pump == 3'h1
            && !external_pixel_clock_select_ff && sampling_phase_ff == 5'h10)
        else $error("fields not at default after reset");
    // Ratio moves one cycle after the data acknowledge rises
    a_ratio_on_ack: assert property (
        !$stable(line_divide_ratio_ff) |-> $past(sda_oe_ff) && !$past(sda_oe_ff, 2))
        else $error("ratio changed outside a write");
    // Derived fields land two cycles behind the acknowledge
    a_cfg_on_write: assert property (
        !$stable(cfg) |-> $past(sda_oe_ff, 2) && !$past(sda_oe_ff, 3))
        else $error("field changed outside a write");
    a_src_excl: assert property (
        pll_feedback_enable_ff != external_pixel_clock_select_ff)
        else $error("clock source flags disagree");
    a_postdiv_band: assert property (
        post_divide_log2_ff == ~oscillator_band_select_ff)
        else $error("post divisor does not follow band");
    a_pump_table: assert property (
        pump_current_ua_ff == UA[pump])
        else $error("pump current mismatch");
    a_span_flag: assert property (
        $stable(line_divide_ratio_ff) |-> ratio_in_span_ff == (line_divide_ratio_ff >= 12'h0DD))
        else $error("span flag wrong");
    c_ext_on: cover property ($rose(external_pixel_clock_select_ff));
    c_ratio_new: cover property (!$stable(line_divide_ratio_ff));
    c_top_band: cover property (oscillator_band_select_ff == 2'h3 && pump == 3'h7);
endmodule
bind pcg_clock_config pcg_monitor u_pcg_monitor (
    .ref_clk(ref_clk), .rst(rst), .sda_oe_ff(sda_oe_ff),
    .line_divide_ratio_ff(line_divide_ratio_ff),
    .pll_feedback_enable_ff(pll_feedback_enable_ff),
    .external_pixel_clock_select_ff(external_pixel_clock_select_ff),
    .oscillator_band_select_ff(oscillator_band_select_ff),
    .post_divide_log2_ff(post_divide_log2_ff), .pump_current_bit2_ff(pump_current_bit2_ff),
    .pump_current_bit1_ff(pump_current_bit1_ff), .pump_current_bit0_ff(pump_current_bit0_ff),
    .pump_current_ua_ff(pump_current_ua_ff), .sampling_phase_ff(sampling_phase_ff),
    .ratio_in_span_ff(ratio_in_span_ff));
`default_nettype wire

//--- tb/pcg_host.sv
// Host model driving the 2-wire control port
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_host (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda
);
    // Idle bus, both lines released; clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Phase of 8 cycles keeps above the 6-cycle minimum
    task automatic hold(input int n = 8);
        repeat (n) @(posedge ref_clk);
    endtask
    // Start or repeated start, ends with clock low
    task automatic start;
        sda <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda <= 1'b0;
        hold();
        scl <= 1'b0;
        hold(2);
    endtask
    task automatic stop;
        sda <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda <= 1'b1;
        hold();
    endtask
    // Data moves 2 cycles after the fall so the device sees the fall first
    task automatic bitx(input logic b, output logic r);
        sda <= b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda_line;
        scl <= 1'b0;
        hold(2);
    endtask
    // Byte MSB first, then the acknowledge slot driven with hb
    task automatic xfer(input logic [7:0] tx, input logic hb, output logic [7:0] rx,
                        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(hb, a);
        ack = !a;
    endtask
    task automatic wr(input logic [7:0] sub, input logic [7:0] dat, output logic [2:0] k);
        logic [7:0] rx;
        start();
        xfer({`PCG_DEV_ADDR, 1'b0}, 1'b1, rx, k[2]);
        xfer(sub, 1'b1, rx, k[1]);
        xfer(dat, 1'b1, rx, k[0]);
        stop();
    endtask
    // Read ends with a NACK
    task automatic rd(input logic [7:0] sub, output logic [7:0] dat, output logic [2:0] k);
        logic [7:0] rx;
        logic       a;
        start();
        xfer({`PCG_DEV_ADDR, 1'b0}, 1'b1, rx, k[2]);
        xfer(sub, 1'b1, rx, k[1]);
        start();
        xfer({`PCG_DEV_ADDR, 1'b1}, 1'b1, rx, k[0]);
        xfer(8'hFF, 1'b1, dat, a);
        stop();
    endtask
    task automatic probe(input logic [6:0] adr, output logic ack);
        logic [7:0] rx;
        start();
        xfer({adr, 1'b0}, 1'b1, rx, ack);
        stop();
    endtask
endmodule
`default_nettype wire

//--- tb/pixel_clock_generator_config_bench.sv
// Self-checking bench for the pixel clock configuration block
`timescale 1ns/1ps
`default_nettype none
module pixel_clock_generator_config_bench;
    localparam logic [7:0]  VER = 8'h5A;  // Arbitrary version code
    localparam logic [15:0] UA [8] = '{16'h0032, 16'h0064, 16'h0096, 16'h00FA,
                                       16'h015E, 16'h01F4, 16'h02EE, 16'h05DC};
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    wire        scl;
    wire        sda_drv;
    wire        sda_line;
    wire        sda_out_ff;
    wire        sda_oe_ff;
    wire [11:0] ratio;
    wire        pll_en;
    wire        ext;
    wire [1:0]  band;
    wire [1:0]  post;
    wire [2:0]  pump;
    wire [10:0] ua;
    wire [4:0]  phase;
    wire        in_span;
    int         miscompares = 0;
    int         compares = 0;
    // Open-drain data wire with pull-up
    assign sda_line = sda_drv & !(sda_oe_ff & !sda_out_ff);
    always #4 ref_clk = ~ref_clk;
    pcg_clock_config #(.SILICON_VERSION(VER)) u_pcg_clock_config (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .line_divide_ratio_ff(ratio),
        .pll_feedback_enable_ff(pll_en), .external_pixel_clock_select_ff(ext),
        .oscillator_band_select_ff(band), .post_divide_log2_ff(post),
        .pump_current_bit2_ff(pump[2]), .pump_current_bit1_ff(pump[1]),
        .pump_current_bit0_ff(pump[0]), .pump_current_ua_ff(ua),
        .sampling_phase_ff(phase), .ratio_in_span_ff(in_span));
    pcg_host u_pcg_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(sda_drv));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bus access wrappers; every slot the device answers must be acknowledged
    task automatic w(input logic [7:0] sub, input logic [7:0] dat);
        logic [2:0] k;
        u_pcg_host.wr(sub, dat, k);
        chk("write acks", k, 16'h0007);
    endtask
    task automatic r(input logic [7:0] sub, input logic [7:0] exp);
        logic [2:0] k;
        logic [7:0] d;
        u_pcg_host.rd(sub, d, k);
        chk("read acks", k, 16'h0007);
        chk($sformatf("reg %h", sub), d, exp);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic t_defaults;
        chk("ratio", ratio, 16'h069D);
        chk("band", band, 16'h0001);
        chk("pump", pump, 16'h0001);
        chk("ua", ua, 16'h0064);
        chk("ext", {pll_en, ext}, 16'h0002);
        chk("phase", phase, 16'h0010);
        r(8'h00, VER);
        r(8'h01, 8'h69);
        r(8'h02, 8'hD0);
        r(8'h03, 8'h48);
        r(8'h04, 8'h80);
        $display("test defaults done");
    endtask
    task automatic t_divider;
        w(8'h01, 8'hAB);
        chk("ratio held", ratio, 16'h069D);
        r(8'h01, 8'hAB);
        w(8'h02, 8'hC5);
        chk("ratio new", ratio, 16'h0ABC);
        r(8'h02, 8'hC0);
        w(8'h01, 8'h0D);
        w(8'h02, 8'hD0);
        chk("ratio min", {in_span, ratio}, 16'h10DD);
        $display("test divider done");
    endtask
    // Every pump code, band and both sources
    task automatic t_clkcfg;
        logic [2:0] c;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            v = {c[1:0], c, c[0], 2'h0};
            w(8'h03, v);
            chk("band", band, c[1:0]);
            chk("post", post, {~c[1:0]});
            chk("pump", pump, c);
            chk("ua", ua, UA[i]);
            chk("src", {pll_en, ext}, {!c[0], c[0]});
            chk("ratio", ratio, 16'h00DD);
            r(8'h03, v);
        end
        $display("test clock config done");
    endtask
    // Phase still applied with external source; reserved bits read 0
    task automatic t_phase;
        logic [4:0] p [3] = '{5'h00, 5'h1F, 5'h0B};
        for (int i = 0; i < 3; i++) begin
            w(8'h04, {p[i], 3'h7});
            chk("phase", {ext, phase}, {1'b1, p[i]});
            r(8'h04, {p[i], 3'h0});
        end
        $display("test phase done");
    endtask
    task automatic t_refuse;
        logic a;
        w(8'h00, 8'hFF);
        r(8'h00, VER);
        r(8'h05, 8'h00);
        u_pcg_host.probe(7'h4D, a);
        chk("foreign address", a, 16'h0000);
        r(8'h04, 8'h58);
        $display("test refusals done");
    endtask
    initial begin
        @(posedge ref_clk);
        do_reset();
        t_defaults();
        t_divider();
        t_clkcfg();
        t_phase();
        t_refuse();
        do_reset();
        t_defaults();
        final_report();
    end
    // Watchdog: the run needs roughly 28000 cycles
    initial begin
        repeat (90000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
